/* File: rtl/usps_port_ctrl.sv */
// Standalone Type-C port signal logic with an APB register window.
// Assumes comparator levels and straps arrive asynchronously on pins.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module usps_port_ctrl #(
  parameter int unsigned RETRY_CYCLES = usps_pkg::RETRY_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [usps_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [usps_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [usps_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cc1_rd_det,
  input wire logic cc2_rd_det,
  input wire logic src_rp_det,
  input wire logic cc1_above_cc2,
  input wire logic vbus_source_permit,
  input wire logic charge_current_sel0,
  input wire logic charge_current_sel1,
  input wire logic supply_fault_in_n,
  input wire logic auto_recover_sel,
  input wire logic fault_report_n_i,
  output logic fault_report_n_o,
  output logic fault_report_n_oe,
  output logic attach,
  output logic orientation,
  output logic port_power,
  output logic [1:0] adv_current,
  output logic irq_n
);
  localparam int NE = usps_pkg::NUM_EV;

  // Pin synchronisation
  usps_pkg::usps_pins_t pins_raw;
  usps_pkg::usps_pins_t s;
  assign pins_raw = '{cc1_rd_det, cc2_rd_det, src_rp_det, cc1_above_cc2,
                      vbus_source_permit, charge_current_sel1, charge_current_sel0,
                      supply_fault_in_n, auto_recover_sel, fault_report_n_i};

  // Idle levels seed the chain, no false fault after reset
  logic [$bits(usps_pkg::usps_pins_t)-1:0] sync_q;
  usps_sync #(.W($bits(usps_pkg::usps_pins_t))) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(pins_raw ^ usps_pkg::PINS_IDLE),
    .q(sync_q)
  );
  assign s = sync_q ^ usps_pkg::PINS_IDLE;

  // Registers
  logic [1:0] ctrl_q;
  logic [NE-1:0] int_status_q;
  logic [NE-1:0] int_status_d;
  logic [NE-1:0] int_enable_q;
  logic cap_done_q;
  logic [1:0] cap_wait_q;
  logic att_q;
  logic flt_q;
  usps_pkg::usps_state_t st_q;
  usps_pkg::usps_state_t st_d;

  // Mode and pin decode
  wire src_mode = ctrl_q[usps_pkg::CTRL_ENABLE_BIT] & ~ctrl_q[usps_pkg::CTRL_SINK_BIT];
  wire snk_mode = ctrl_q[usps_pkg::CTRL_ENABLE_BIT] & ctrl_q[usps_pkg::CTRL_SINK_BIT];
  wire att_src = s.cc1_rd_det | s.cc2_rd_det;
  wire att_now = src_mode ? att_src : (snk_mode & s.src_rp_det);
  wire orient_now = src_mode ? s.cc2_rd_det : ~s.cc1_above_cc2;
  wire flt = src_mode & ~s.supply_fault_in_n;
  wire permit = s.vbus_source_permit;
  wire retry_done;

  // APB decode
  wire apb_setup = psel & ~penable;
  wire apb_acc = psel & penable & pready;
  wire apb_wr = apb_acc & pwrite & pstrb[0];
  wire hit_ctrl = (paddr == usps_pkg::OFS_CTRL);
  wire hit_stat = (paddr == usps_pkg::OFS_STATUS);
  wire hit_ist = (paddr == usps_pkg::OFS_INT_STATUS);
  wire hit_iclr = (paddr == usps_pkg::OFS_INT_CLEAR);
  wire hit_ien = (paddr == usps_pkg::OFS_INT_ENABLE);
  wire hit_any = hit_ctrl | hit_stat | hit_ist | hit_iclr | hit_ien;
  wire bad_acc = ~hit_any | (pwrite & (hit_stat | hit_ist)) | (~pwrite & hit_iclr);
  wire [NE-1:0] int_clr = (apb_wr & hit_iclr) ? pwdata[NE-1:0] : '0;

  logic [usps_pkg::DATA_W-1:0] rd_mux;
  assign rd_mux =
    hit_ctrl ? {30'h0, ctrl_q} :
    hit_stat ? {22'h0, st_q, s.fault_report_n_i, adv_current, (st_q == usps_pkg::USPS_FAULT),
                flt, port_power, orientation, attach} :
    hit_ist ? {28'h0, int_status_q} :
    hit_ien ? {28'h0, int_enable_q} : 32'h0;

  // Interrupt events
  logic [NE-1:0] ev;
  assign ev[usps_pkg::EV_ATTACH] = att_now & ~att_q;
  assign ev[usps_pkg::EV_DETACH] = ~att_now & att_q;
  assign ev[usps_pkg::EV_SUPPLY_FAULT] = flt & ~flt_q;
  assign ev[usps_pkg::EV_POWER_ON] = (st_d == usps_pkg::USPS_POWERED) & ~port_power;
  // Set wins over a clear in the same cycle
  assign int_status_d = (int_status_q & ~int_clr) | ev;

  // Port state machine
  always_comb begin
    st_d = st_q;
    case (st_q)
      usps_pkg::USPS_IDLE: begin
        if (att_now & src_mode) begin
          st_d = usps_pkg::USPS_ATTACHED;
        end
      end
      usps_pkg::USPS_ATTACHED: begin
        if (!att_now) begin
          st_d = usps_pkg::USPS_IDLE;
        end else if (flt) begin
          st_d = usps_pkg::USPS_FAULT;
        end else if (permit) begin
          st_d = usps_pkg::USPS_POWERED;
        end
      end
      usps_pkg::USPS_POWERED: begin
        if (!att_now) begin
          st_d = usps_pkg::USPS_IDLE;
        end else if (flt) begin
          st_d = usps_pkg::USPS_FAULT;
        end else if (!permit) begin
          st_d = usps_pkg::USPS_ATTACHED;
        end
      end
      usps_pkg::USPS_FAULT: begin
        if (!att_now) begin
          st_d = usps_pkg::USPS_IDLE;
        end else if (s.auto_recover_sel & retry_done & ~flt) begin
          st_d = usps_pkg::USPS_ATTACHED;
        end
      end
      default: st_d = usps_pkg::USPS_IDLE;
    endcase
    if (!src_mode) begin
      st_d = usps_pkg::USPS_IDLE;
    end
  end

  wire fault_enter = (st_d == usps_pkg::USPS_FAULT) & (st_q != usps_pkg::USPS_FAULT);

  usps_timer #(.CW(usps_pkg::RETRY_CNT_W)) u_retry (
    .clk(pclk),
    .rst_n(presetn),
    .start(fault_enter),
    .count(usps_pkg::RETRY_CNT_W'(RETRY_CYCLES)),
    .done(retry_done)
  );

  // State and port outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= usps_pkg::USPS_IDLE;
      att_q <= 1'b0;
      flt_q <= 1'b0;
      attach <= 1'b0;
      orientation <= 1'b0;
      port_power <= 1'b0;
      fault_report_n_o <= 1'b0;
      fault_report_n_oe <= 1'b0;
    end else begin
      st_q <= st_d;
      att_q <= att_now;
      flt_q <= flt;
      attach <= att_now;
      orientation <= att_now & orient_now;
      port_power <= (st_d == usps_pkg::USPS_POWERED);
      fault_report_n_o <= 1'b0;
      fault_report_n_oe <= flt;
    end
  end

  // Charge current straps caught once the synchroniser holds them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_wait_q <= 2'h0;
      cap_done_q <= 1'b0;
      adv_current <= usps_pkg::USPS_CUR_USB2;
    end else if (!cap_done_q) begin
      cap_wait_q <= cap_wait_q + 2'h1;
      if (cap_wait_q == usps_pkg::CAP_WAIT) begin
        cap_done_q <= 1'b1;
        adv_current <= {s.charge_current_sel1, s.charge_current_sel0};
      end
    end
  end

  // Register file and interrupt output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= usps_pkg::CTRL_RESET;
      int_enable_q <= usps_pkg::INT_ENABLE_RESET;
      int_status_q <= '0;
      irq_n <= 1'b1;
    end else begin
      if (apb_wr & hit_ctrl) begin
        ctrl_q <= pwdata[1:0];
      end
      if (apb_wr & hit_ien) begin
        int_enable_q <= pwdata[NE-1:0];
      end
      int_status_q <= int_status_d;
      irq_n <= ~|(int_status_q & int_enable_q);
    end
  end

  // APB completer, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & bad_acc;
      if (psel & penable & ~pready & ~pwrite) begin
        prdata <= rd_mux;
      end else if (apb_setup) begin
        prdata <= 32'h0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_fault_seen;
    flt && !flt_q;
  endsequence

  sequence s_power_request;
    st_q == usps_pkg::USPS_ATTACHED && att_now && permit && !flt && src_mode;
  endsequence

  sequence s_retry_ready;
    st_q == usps_pkg::USPS_FAULT && s.auto_recover_sel && retry_done && !flt && att_now &&
      src_mode;
  endsequence

  a_power_needs_permit: assert property (
    port_power |-> $past(permit))
    else $error("port power on without permit");
  a_power_on_attach: assert property (
    s_power_request |=> port_power)
    else $error("port power not raised on permitted attach");
  a_attach_follows: assert property (
    src_mode && $past(src_mode) |=> attach == $past(att_src))
    else $error("attach does not follow cc terminations");
  a_orient_source: assert property (
    src_mode && att_src |=> orientation == $past(s.cc2_rd_det))
    else $error("source orientation wrong");
  a_orient_sink: assert property (
    snk_mode && s.src_rp_det |=> orientation == !$past(s.cc1_above_cc2))
    else $error("sink orientation wrong");
  a_fault_report_low: assert property (
    flt |=> fault_report_n_oe && !fault_report_n_o)
    else $error("fault report not driven low");
  a_fault_irq_set: assert property (
    s_fault_seen |=> int_status_q[usps_pkg::EV_SUPPLY_FAULT])
    else $error("supply fault interrupt not set");
  a_irq_low_pending: assert property (
    |(int_status_q & int_enable_q) |=> !irq_n)
    else $error("interrupt output not asserted");
  a_power_off_fault: assert property (
    port_power && flt |=> !port_power)
    else $error("port power held during fault");
  a_no_recover: assert property (
    st_q == usps_pkg::USPS_FAULT && !s.auto_recover_sel && att_now && src_mode
      |=> st_q == usps_pkg::USPS_FAULT)
    else $error("recovered without auto recover");
  a_current_held: assert property (
    cap_done_q |=> $stable(adv_current))
    else $error("advertised current changed after capture");

  // Further port output, interrupt status and state checks
  a_adv_capture: assert property (
    !cap_done_q && cap_wait_q == usps_pkg::CAP_WAIT
      |=> adv_current == $past({s.charge_current_sel1, s.charge_current_sel0}))
    else $error("charge current straps not captured");
  a_attach_idle: assert property (
    !att_now |=> !attach)
    else $error("attach high with nothing attached");
  a_attach_event: assert property (
    att_now && !att_q |=> int_status_q[usps_pkg::EV_ATTACH])
    else $error("attach event not recorded");
  a_orient_detached: assert property (
    !att_now |=> !orientation)
    else $error("orientation high while detached");
  a_fault_pin_release: assert property (
    !flt |=> !fault_report_n_oe)
    else $error("fault report driven without fault");
  a_sink_pin_idle: assert property (
    snk_mode |=> !fault_report_n_oe)
    else $error("fault report driven in sink mode");
  a_fault_sticky: assert property (
    int_status_q[usps_pkg::EV_SUPPLY_FAULT] && !int_clr[usps_pkg::EV_SUPPLY_FAULT]
      |=> int_status_q[usps_pkg::EV_SUPPLY_FAULT])
    else $error("supply fault status lost without clear");
  a_no_power_sink: assert property (
    !src_mode |=> !port_power)
    else $error("port power on outside source mode");
  a_power_needs_attach: assert property (
    port_power |-> $past(att_now))
    else $error("port power on without attach");
  a_recover_retry: assert property (
    s_retry_ready |=> st_q == usps_pkg::USPS_ATTACHED)
    else $error("no recovery after retry time");
  a_irq_high_idle: assert property (
    !(|(int_status_q & int_enable_q)) |=> irq_n)
    else $error("interrupt output low with nothing pending");
  a_power_off_detach: assert property (
    port_power && !att_now |=> !port_power)
    else $error("port power held after detach");
  a_power_off_permit: assert property (
    port_power && !permit |=> !port_power)
    else $error("port power held after permit loss");
  a_fault_no_power: assert property (
    st_q == usps_pkg::USPS_FAULT |-> !port_power)
    else $error("port power on in fault state");
endmodule
`default_nettype wire

/* File: rtl/usps_pkg.sv */
// Package: shared constants and types for the standalone port signal block.
// Assumes a 20 MHz pclk and an APB completer with 8 address bits.
package usps_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_STATUS = 8'h08;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h0C;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h10;
  localparam int CTRL_SINK_BIT = 0;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  localparam logic [3:0] INT_ENABLE_RESET = 4'h0;
  localparam int EV_ATTACH = 0;
  localparam int EV_DETACH = 1;
  localparam int EV_SUPPLY_FAULT = 2;
  localparam int EV_POWER_ON = 3;
  localparam int NUM_EV = 4;
  localparam int CLK_FREQ_KHZ = 20000;
  localparam int RETRY_TIME_MS = 10;
  localparam int RETRY_CYCLES = RETRY_TIME_MS * CLK_FREQ_KHZ;
  localparam int RETRY_CNT_W = 18;
  localparam logic [1:0] CAP_WAIT = 2'h2;

  typedef enum logic [1:0] {
    USPS_IDLE = 2'h0,
    USPS_ATTACHED = 2'h1,
    USPS_POWERED = 2'h3,
    USPS_FAULT = 2'h2
  } usps_state_t;

  typedef enum logic [1:0] {
    USPS_CUR_USB2 = 2'h0,
    USPS_CUR_USB3 = 2'h1,
    USPS_CUR_1A5 = 2'h2,
    USPS_CUR_3A0 = 2'h3
  } usps_current_t;

  typedef struct packed {
    logic cc1_rd_det;
    logic cc2_rd_det;
    logic src_rp_det;
    logic cc1_above_cc2;
    logic vbus_source_permit;
    logic charge_current_sel1;
    logic charge_current_sel0;
    logic supply_fault_in_n;
    logic auto_recover_sel;
    logic fault_report_n_i;
  } usps_pins_t;

  localparam usps_pins_t PINS_IDLE = '{supply_fault_in_n: 1'b1, fault_report_n_i: 1'b1,
                                       default: 1'b0};
endpackage

/* File: rtl/usps_sync.sv */
// Two-flop synchroniser for a bundle of pin levels.
// Assumes each bit is a slow level; no bus coherency is implied.
`timescale 1ns/1ps
`default_nettype none
module usps_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/usps_timer.sv */
// Down counter: a start pulse loads the count, done is high once it reaches zero.
// Assumes start is a one-cycle pulse from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module usps_timer #(
  parameter int CW = 18
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [CW-1:0] count,
  output logic done
);
  logic [CW-1:0] cnt_q;
  logic run_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      cnt_q <= count;
      run_q <= 1'b1;
      done <= 1'b0;
    end else if (run_q) begin
      cnt_q <= cnt_q - CW'(1);
      run_q <= (cnt_q > CW'(1));
      done <= (cnt_q <= CW'(1));
    end
  end
endmodule
`default_nettype wire

/* File: dv/usps_host_model.sv */
// Host port-power and supply switch model: permit, supply fault, fault pin.
// Assumes bench requests are levels in the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module usps_host_model (
  input wire logic pclk,
  input wire logic permit_req,
  input wire logic fault_req,
  input wire logic fault_report_n_o,
  input wire logic fault_report_n_oe,
  output var logic vbus_source_permit,
  output var logic supply_fault_in_n,
  output logic fault_pin
);
  initial begin
    vbus_source_permit = 1'b0;
    supply_fault_in_n = 1'b1;
  end
  always @(posedge pclk) begin
    vbus_source_permit <= permit_req;
    supply_fault_in_n <= ~fault_req;
  end
  // Pull-up while released
  assign fault_pin = fault_report_n_oe ? fault_report_n_o : 1'b1;
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Bench: APB and pin stimulus for the port block, with output checks.
// Assumes the host model supplies permit, supply fault and fault pin level.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, permit, fault_n, pin, f_o, f_oe, attach, orient, pwr, irq_n;
  logic cc1 = 1'b0, cc2 = 1'b0, rp = 1'b0, hi1 = 1'b0, sel0 = 1'b0, sel1 = 1'b0;
  logic arec = 1'b0, permit_req = 1'b0, fault_req = 1'b0;
  logic [1:0] adv;
  int err_total = 0, cmp_count = 0;
  always #25 pclk = ~pclk;
  usps_port_ctrl #(.RETRY_CYCLES(20)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cc1_rd_det(cc1), .cc2_rd_det(cc2),
    .src_rp_det(rp), .cc1_above_cc2(hi1), .vbus_source_permit(permit),
    .charge_current_sel0(sel0), .charge_current_sel1(sel1), .supply_fault_in_n(fault_n),
    .auto_recover_sel(arec), .fault_report_n_i(pin), .fault_report_n_o(f_o),
    .fault_report_n_oe(f_oe), .attach(attach), .orientation(orient), .port_power(pwr),
    .adv_current(adv), .irq_n(irq_n));
  usps_host_model host_u (.pclk(pclk), .permit_req(permit_req), .fault_req(fault_req),
    .fault_report_n_o(f_o), .fault_report_n_oe(f_oe), .vbus_source_permit(permit),
    .supply_fault_in_n(fault_n), .fault_pin(pin));
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic chk1(input string nm, input logic ex, input logic got);
    chk(nm, {31'h0, ex}, {31'h0, got});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(a, 1'b0, 32'h0);
    chk(nm, ex, rd);
  endtask
  task automatic do_reset(input logic [1:0] code);
    presetn <= 1'b0;
    sel1 <= code[1];
    sel0 <= code[0];
    wt(16);
    presetn <= 1'b1;
    wt(6);
    chk("adv_current", {30'h0, code}, {30'h0, adv});
  endtask
  initial begin
    wt(5000);
    err_total++;
    end_of_test();
  end
  initial begin
    for (int c = 0; c < 4; c++) begin
      do_reset(c[1:0]);
    end
    rdchk("ctrl_reset", usps_pkg::OFS_CTRL, {30'h0, usps_pkg::CTRL_RESET});
    rdchk("int_en_reset", usps_pkg::OFS_INT_ENABLE, 32'h0);
    apb(8'h14, 1'b1, 32'hF);
    chk1("unmapped_err", 1'b1, er);
    apb(usps_pkg::OFS_INT_ENABLE, 1'b1, 32'hF);
    chk1("irq_idle", 1'b1, irq_n);
    cc2 <= 1'b1;
    wt(8);
    chk1("attach", 1'b1, attach);
    chk1("orient_cc2", 1'b1, orient);
    chk1("power_no_permit", 1'b0, pwr);
    chk1("irq_attach", 1'b0, irq_n);
    permit_req <= 1'b1;
    wt(8);
    chk1("power_on", 1'b1, pwr);
    rdchk("status_powered", usps_pkg::OFS_STATUS, 32'h3E7);
    rdchk("int_status", usps_pkg::OFS_INT_STATUS, 32'h9);
    apb(usps_pkg::OFS_INT_CLEAR, 1'b1, 32'hF);
    rdchk("int_cleared", usps_pkg::OFS_INT_STATUS, 32'h0);
    chk1("irq_cleared", 1'b1, irq_n);
    fault_req <= 1'b1;
    wt(8);
    chk1("power_fault", 1'b0, pwr);
    chk1("fault_pin", 1'b0, pin);
    rdchk("int_fault", usps_pkg::OFS_INT_STATUS, 32'h4);
    fault_req <= 1'b0;
    wt(60);
    chk1("no_recover", 1'b0, pwr);
    chk1("pin_released", 1'b1, pin);
    cc2 <= 1'b0;
    wt(8);
    chk1("detach", 1'b0, attach);
    arec <= 1'b1;
    cc1 <= 1'b1;
    wt(8);
    chk1("orient_cc1", 1'b0, orient);
    chk1("repower", 1'b1, pwr);
    fault_req <= 1'b1;
    wt(8);
    fault_req <= 1'b0;
    wt(60);
    chk1("recovered", 1'b1, pwr);
    permit_req <= 1'b0;
    wt(8);
    chk1("permit_drop", 1'b0, pwr);
    permit_req <= 1'b1;
    wt(8);
    cc1 <= 1'b0;
    wt(8);
    chk1("detach_drop", 1'b0, pwr);
    apb(usps_pkg::OFS_CTRL, 1'b1, 32'h3);
    rp <= 1'b1;
    wt(8);
    chk1("sink_attach", 1'b1, attach);
    chk1("sink_orient_cc2", 1'b1, orient);
    hi1 <= 1'b1;
    wt(8);
    chk1("sink_orient_cc1", 1'b0, orient);
    apb(usps_pkg::OFS_CTRL, 1'b1, 32'h0);
    wt(4);
    chk1("disabled_attach", 1'b0, attach);
    chk1("disabled_orient", 1'b0, orient);
    end_of_test();
  end
endmodule
`default_nettype wire
